// [hw/mbu_unpacker.sv]
// mirror block unpacker: 192-bit link words in, whole 1024-column rows out
// assumes the link side holds word_i stable while word_valid_i is high
// and that block_start_i comes from decoding the block control word
`timescale 1ns/1ps
// Behaviour
// [R01] block is 1024 columns by 136 rows
// [R02] full block is 726 words, consumed in order
// [R03] last full-block word uses bits 0-63 only
// [R04] ascending bits fill ascending columns, rows wrap
// [R05] increment direction starts at row 0 upward
// [R06] decrement direction starts at row 135
// [R07] decrement keeps packing, row becomes 135 minus k
// [R08] partial block maps only row-length rows
// [R09] bit offset tracked, pattern repeats every three rows
module mbu_unpacker
  import mbu_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // block control
  input wire logic block_start_i,
  input wire logic block_decrement_i,
  input wire logic [ROW_W-1:0] block_rows_i,
  // link word stream
  input wire logic word_valid_i,
  input wire logic [WORD_W-1:0] word_i,
  output logic word_ready_o,
  // row output
  output logic row_valid_o,
  output logic [ROW_W-1:0] row_index_o,
  output logic [COLS-1:0] row_data_o,
  output logic block_done_o,
  output logic [9:0] word_count_o
);
  // ==========================================================
  // state
  typedef enum logic {
    MBU_IDLE,
    MBU_FILL
  } mbu_state_t;

  mbu_state_t state_reg;
  mbu_state_t state_next;
  logic decrement_reg;
  logic decrement_next;
  logic [ROW_W-1:0] rows_reg;
  logic [ROW_W-1:0] rows_next;
  logic [ROW_W-1:0] row_cnt_reg;
  logic [ROW_W-1:0] row_cnt_next;
  logic [FILL_W-1:0] fill_reg;
  logic [FILL_W-1:0] fill_next;
  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic row_valid_reg;
  logic [ROW_W-1:0] row_index_reg;
  logic [ROW_W-1:0] row_index_next;
  logic [COLS-1:0] row_data_reg;
  logic [COLS-1:0] row_data_next;
  logic done_reg;
  logic [9:0] word_cnt_reg;
  logic [9:0] word_cnt_next;

  mbu_pack_if pk ();

  mbu_row_packer u_packer (
    .p(pk)
  );

  // ==========================================================
  // decode
  wire active = (state_reg == MBU_FILL);
  // a start on the same edge wins over a word in flight
  wire take_word = active & word_valid_i & ~block_start_i;
  wire row_emit = take_word & pk.row_full;
  wire last_row = (row_cnt_reg == (rows_reg - 8'h01));
  wire block_end = row_emit & last_row;
  // zero or oversize row length falls back to a full block; see [R08]
  wire rows_bad = (block_rows_i == ROW_RST) | (block_rows_i > ROW_COUNT_FULL);
  // full block is 136 rows of 1024 columns; see [R01]
  wire [ROW_W-1:0] rows_eff = rows_bad ? ROW_COUNT_FULL : block_rows_i;
  // stream row k lands at 135 minus k when decrementing; see [R06] [R07]
  wire [ROW_W-1:0] row_dest = decrement_reg ? (ROW_LAST - row_cnt_reg) : row_cnt_reg;

  assign pk.word = word_i;
  assign pk.fill = fill_reg;
  assign pk.acc = acc_reg;

  // ==========================================================
  // block state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MBU_IDLE: begin
        if (block_start_i) begin
          state_next = MBU_FILL;
        end
      end
      MBU_FILL: begin
        // stop taking words once the last wanted row is out; see [R02] [R08]
        if (block_start_i) begin
          state_next = MBU_FILL;
        end else if (block_end) begin
          state_next = MBU_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // next values
  // direction and length are latched only with the start pulse
  assign decrement_next = block_start_i ? block_decrement_i : decrement_reg;
  assign rows_next = block_start_i ? rows_eff : rows_reg;
  // first row is stream row 0 in either direction; see [R05] [R06]
  wire [ROW_W-1:0] row_cnt_inc = row_emit ? (row_cnt_reg + 8'h01) : row_cnt_reg;
  assign row_cnt_next = block_start_i ? ROW_RST : row_cnt_inc;

  // leftover of the final word is dropped, e.g. bits 64-191; see [R03]
  wire acc_clear = block_start_i | block_end;
  wire [ACC_W-1:0] acc_word = pk.row_full ? pk.leftover : pk.merged; // see [R04]
  wire [ACC_W-1:0] acc_keep = take_word ? acc_word : acc_reg;
  wire [FILL_W-1:0] fill_keep = take_word ? pk.fill_next : fill_reg; // see [R09]
  assign acc_next = acc_clear ? '0 : acc_keep;
  assign fill_next = acc_clear ? FILL_RST : fill_keep;

  assign row_index_next = row_emit ? row_dest : row_index_reg; // see [R05] [R07]
  assign row_data_next = row_emit ? pk.merged[COLS-1:0] : row_data_reg;
  // counts words of the current block, 726 for a full one; see [R02]
  wire [9:0] word_cnt_inc = take_word ? (word_cnt_reg + 10'h001) : word_cnt_reg;
  assign word_cnt_next = block_start_i ? 10'h000 : word_cnt_inc;

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= MBU_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      decrement_reg <= 1'b0;
    end else begin
      decrement_reg <= decrement_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rows_reg <= ROW_COUNT_FULL;
    end else begin
      rows_reg <= rows_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_cnt_reg <= ROW_RST;
    end else begin
      row_cnt_reg <= row_cnt_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_reg <= FILL_RST;
    end else begin
      fill_reg <= fill_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_reg <= '0;
    end else begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_valid_reg <= 1'b0;
    end else begin
      row_valid_reg <= row_emit;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_index_reg <= ROW_RST;
    end else begin
      row_index_reg <= row_index_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      row_data_reg <= '0;
    end else begin
      row_data_reg <= row_data_next;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= block_end;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      word_cnt_reg <= 10'h000;
    end else begin
      word_cnt_reg <= word_cnt_next;
    end
  end

  assign word_ready_o = active;
  assign row_valid_o = row_valid_reg;
  assign row_index_o = row_index_reg;
  assign row_data_o = row_data_reg;
  assign block_done_o = done_reg;
  assign word_count_o = word_cnt_reg;
endmodule : mbu_unpacker

// [hw/mbu_pkg.sv]
// constants shared by the block unpacker and its packer helper
// assumes nothing of its surroundings
package mbu_pkg;
  // ==========================================================
  // array geometry
  localparam int COLS = 1024;
  localparam int ROWS = 136;
  localparam int WORD_W = 192;
  localparam int FULL_WORDS = 726;
  localparam int ACC_W = COLS + WORD_W;
  localparam int FILL_W = 11;
  localparam int ROW_W = 8;
  // ==========================================================
  // typed counts
  localparam logic [FILL_W-1:0] WORD_STEP = 11'h0C0;
  localparam logic [FILL_W-1:0] ROW_BITS = 11'h400;
  localparam logic [ROW_W-1:0] ROW_LAST = 8'h87;
  localparam logic [ROW_W-1:0] ROW_COUNT_FULL = 8'h88;
  // ==========================================================
  // reset values
  localparam logic [FILL_W-1:0] FILL_RST = 11'h000;
  localparam logic [ROW_W-1:0] ROW_RST = 8'h00;
endpackage : mbu_pkg

// [hw/mbu_pack_if.sv]
// carrier between the unpacker registers and the packing logic
// assumes both ends are in one clock domain
`timescale 1ns/1ps
interface mbu_pack_if;
  import mbu_pkg::*;
  logic [WORD_W-1:0] word;
  logic [FILL_W-1:0] fill;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] merged;
  logic [ACC_W-1:0] leftover;
  logic [FILL_W-1:0] fill_next;
  logic row_full;
  modport owner (
    output word, fill, acc,
    input merged, leftover, fill_next, row_full
  );
  modport packer (
    input word, fill, acc,
    output merged, leftover, fill_next, row_full
  );
endinterface : mbu_pack_if

// [hw/mbu_row_packer.sv]
// combinational placer: drops one link word into the row accumulator
// assumes bits of acc at and above fill are zero
`timescale 1ns/1ps
module mbu_row_packer
  import mbu_pkg::*;
(
  mbu_pack_if.packer p
);
  // ==========================================================
  // placement
  wire [ACC_W-1:0] word_wide = {{(ACC_W-WORD_W){1'b0}}, p.word};
  wire [FILL_W-1:0] fill_sum = p.fill + WORD_STEP;

  // ascending bits go to ascending columns from the current offset; see [R04]
  assign p.merged = p.acc | (word_wide << p.fill);
  assign p.row_full = (fill_sum >= ROW_BITS);
  // upper bits of a word start the next row at column 0; see [R04]
  assign p.leftover = p.merged >> COLS;
  // offset cycles 0, 128, 64 so the pattern repeats each three rows; see [R09]
  assign p.fill_next = p.row_full ? (fill_sum - ROW_BITS) : fill_sum;
endmodule : mbu_row_packer

// [verif/mbu_props.sv]
// port assertions for mbu_unpacker; bound onto it below
`timescale 1ns/1ps
module mbu_props
  import mbu_pkg::*;
(
  input logic clk_i,
  input logic rst_i,
  input logic block_start_i,
  input logic word_valid_i,
  input logic word_ready_o,
  input logic row_valid_o,
  input logic [COLS-1:0] row_data_o,
  input logic block_done_o,
  input logic [9:0] word_count_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence tk_s;
    word_valid_i && word_ready_o && !block_start_i;
  endsequence
  start_ok_a: assert property (block_start_i |=> word_ready_o && !word_count_o)
    else $error("bad start");
  count_up_a: assert property (tk_s |=> word_count_o == $past(word_count_o) + 1)
    else $error("bad count");
  idle_hold_a: assert property (!word_ready_o && !block_start_i |=> $stable(word_count_o))
    else $error("count moved");
  row_zero_a: assert property (tk_s ##0 word_count_o == 5 |=> row_valid_o)
    else $error("row late");
  no_early_a: assert property (tk_s ##0 word_count_o < 5 |=> !row_valid_o)
    else $error("row early");
  row_two_a: assert property (tk_s ##0 word_count_o == 15 |=> row_valid_o)
    else $error("row late");
  last_done_a: assert property (block_done_o |-> row_valid_o && !word_ready_o)
    else $error("bad done");
  data_keep_a: assert property (!row_valid_o |-> $stable(row_data_o))
    else $error("row moved");
endmodule : mbu_props

bind mbu_unpacker mbu_props i_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .block_start_i(block_start_i),
  .word_valid_i(word_valid_i),
  .word_ready_o(word_ready_o),
  .row_valid_o(row_valid_o),
  .row_data_o(row_data_o),
  .block_done_o(block_done_o),
  .word_count_o(word_count_o)
);

// [verif/mbu_src.sv]
// link word source with stalls; en_i low restarts it at word 0
`timescale 1ns/1ps
module mbu_src
  import mbu_pkg::*;
(
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic slow_i,
  input wire logic word_ready_o,
  output logic word_valid_i = 1'b0,
  output logic [WORD_W-1:0] word_i = '0
);
  logic [WORD_W-1:0] sent [FULL_WORDS];
  logic tk, e;
  int n = 0;
  always @(posedge clk_i) begin
    tk = word_valid_i && word_ready_o;
    e = en_i;
    #1;
    n = e ? n + tk : 0;
    if (tk || !word_valid_i || !e) begin
      word_valid_i = e && n < FULL_WORDS && !(slow_i && $urandom_range(2) == 0);
      // an idle line inverts every bit on each idle cycle, so it toggles between the inverse of its last word and that word
      for (int j = 0; j < 6; j++)
        word_i[32*j+:32] = word_valid_i ? $urandom : ~word_i[32*j+:32];
      if (word_valid_i) sent[n] = word_i;
    end
  end
endmodule : mbu_src

// [verif/tb_mbu_unpacker.sv]
// bench for mbu_unpacker, fed by mbu_src
`timescale 1ns/1ps
module tb_mbu_unpacker;
  import mbu_pkg::*;
  logic clk_i = 0, rst_i = 1, block_start_i = 0, block_decrement_i = 0, en_i = 0, slow_i = 0;
  logic [ROW_W-1:0] block_rows_i = 8'h00, row_index_o;
  logic word_valid_i, word_ready_o, row_valid_o, block_done_o;
  logic [WORD_W-1:0] word_i;
  logic [COLS-1:0] row_data_o;
  logic [9:0] word_count_o;
  int bad_count = 0, tests_run = 0, cyc = 0;
  initial forever #50 clk_i = ~clk_i;
  mbu_unpacker i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .block_start_i(block_start_i),
    .block_decrement_i(block_decrement_i),
    .block_rows_i(block_rows_i),
    .word_valid_i(word_valid_i),
    .word_i(word_i),
    .word_ready_o(word_ready_o),
    .row_valid_o(row_valid_o),
    .row_index_o(row_index_o),
    .row_data_o(row_data_o),
    .block_done_o(block_done_o),
    .word_count_o(word_count_o)
  );
  mbu_src i_src (
    .clk_i(clk_i),
    .en_i(en_i),
    .slow_i(slow_i),
    .word_ready_o(word_ready_o),
    .word_valid_i(word_valid_i),
    .word_i(word_i)
  );
  task close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out
  // zero or oversize row length means a full block
  function automatic int exp_rows(int r);
    exp_rows = (r == 0 || r > ROWS) ? ROWS : r;
  endfunction : exp_rows
  task chk(input string nm, input logic [COLS-1:0] e, v);
    tests_run++;
    if (e !== v) begin
      bad_count++;
      $display("unexpected %s exp %0h got %0h", nm, e, v);
    end
  endtask : chk
  function automatic logic [COLS-1:0] exp_row(int k);
    for (int c = 0; c < COLS; c++) exp_row[c] = i_src.sent[(COLS*k+c)/WORD_W][(COLS*k+c)%WORD_W];
  endfunction : exp_row
  task run(input logic d, input int r, input logic s);
    int k;
    int n;
    k = 0;
    n = exp_rows(r);
    {en_i, slow_i, block_start_i, block_decrement_i, block_rows_i} = {1'b0, s, 1'b1, d, r[7:0]};
    @(posedge clk_i) #1 {block_start_i, en_i} = 2'b01;
    while (k < n) begin
      @(posedge clk_i) #1 cyc++;
      if (cyc == 9000) begin
        bad_count++;
        close_out();
      end
      if (row_valid_o === 1'b1) begin
        chk("row index", d ? ROW_LAST - k : k, row_index_o);
        chk("row data", exp_row(k), row_data_o);
        chk("done", k == n - 1, block_done_o);
        k++;
      end
    end
    chk("count", (COLS * n + WORD_W - 1) / WORD_W, word_count_o);
    $display("block test done rows %0d down %0d", r, d);
  endtask : run
  initial begin
    void'($urandom(32'hD7123421));
    repeat (6) @(posedge clk_i);
    #1 rst_i = 0;
    run(0, 136, 1);
    run(1, 136, 0);
    run(0, 3, 0);
    run(1, 1, 1);
    run(0, 0, 0);
    run($urandom_range(1) == 1, $urandom_range(1, 40), $urandom_range(1) == 1);
    close_out();
  end
endmodule : tb_mbu_unpacker
